// File: lcd_bias_i2c_slave_port.sv
// I2C target port holding the LCD bias configuration registers
`timescale 1ns/1ps
`default_nettype none
module lcd_bias_i2c_slave_port #(
   parameter logic [6:0] OWN_ADDR = lcd_bias_pkg::TARGET_ADDR
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // Serial bus pins
   input  wire logic                          scl_i,
   input  wire logic                          sda_i,
   output var  logic                          sda_o,
   output var  logic                          sda_oe,
   // Configuration out and busy flag
   output var  logic [lcd_bias_pkg::POS_W-1:0] pos_code,
   output var  logic [lcd_bias_pkg::NEG_W-1:0] neg_code,
   output var  logic [lcd_bias_pkg::DIS_W-1:0] dis_en,
   output var  logic                          busy
);
   import lcd_bias_pkg::*;

   // Address zero is the general call and can never be ours
   if (OWN_ADDR == 7'h00) begin : g_addr_check
      $error("General call address cannot be the target address");
   end

   logic        scl_s;
   logic        sda_s;
   logic        scl_d1_q;
   logic        sda_d1_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   port_state_e state_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  shift_q;
   logic [7:0]  ptr_q;
   logic [7:0]  tx_q;
   logic        ack_slot_q;
   logic        drive_ack_q;
   logic        rd_nack_q;
   logic [7:0]  rx_byte;
   logic [7:0]  rd_next;

   lcd_bias_sync #(.RESET_VAL(1'b1)) u_sync_scl (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (scl_i),
      .q     (scl_s)
   );
   lcd_bias_sync #(.RESET_VAL(1'b1)) u_sync_sda (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (sda_i),
      .q     (sda_s)
   );

   function automatic logic [7:0] read_reg(input logic [7:0] p,
                                           input logic [3:0] pv,
                                           input logic [3:0] nv,
                                           input logic [1:0] dv);
      logic [7:0] r;
      r = 8'h00;
      case (p)
         REG_POS: r = {4'h0, pv};
         REG_NEG: r = {4'h0, nv};
         REG_DIS: r = {6'h00, dv};
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
      end else begin
         scl_d1_q <= scl_s;
         sda_d1_q <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_d1_q;
   assign scl_fall  = ~scl_s & scl_d1_q;
   // Data edges with clock high are conditions, never bits
   assign start_det = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
   assign stop_det  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
   assign rx_byte   = {shift_q[6:0], sda_s};
   // Byte to send next: the pointed register after a read address, its successor later
   assign rd_next   = read_reg(state_q == ST_ADDR ? ptr_q : ptr_q + 8'h01,
                               pos_code, neg_code, dis_en);

   // Bit sequencing: 8 data bits then the acknowledge slot
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= ST_IDLE;
         bit_cnt_q  <= 4'h0;
         shift_q    <= 8'h00;
         ack_slot_q <= 1'b0;
         rd_nack_q  <= 1'b0;
      end else if (start_det) begin
         state_q    <= ST_ADDR;
         bit_cnt_q  <= 4'h0;
         ack_slot_q <= 1'b0;
         rd_nack_q  <= 1'b0;
      end else if (stop_det) begin
         state_q    <= ST_IDLE;
         bit_cnt_q  <= 4'h0;
         ack_slot_q <= 1'b0;
         rd_nack_q  <= 1'b0;
      end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
         if (scl_rise) begin
            if (ack_slot_q) begin
               // Master acknowledge on a read keeps the stream going
               if (state_q == ST_RDATA && sda_s) rd_nack_q <= 1'b1;
            end else begin
               shift_q   <= rx_byte;
               bit_cnt_q <= bit_cnt_q + 4'h1;
            end
         end else if (scl_fall) begin
            if (ack_slot_q) begin
               ack_slot_q <= 1'b0;
               bit_cnt_q  <= 4'h0;
               if (state_q == ST_ADDR) begin
                  state_q <= shift_q[0] ? ST_RDATA : ST_PTR;
               end else if (state_q == ST_PTR) begin
                  state_q <= ST_WDATA;
               end else if (state_q == ST_RDATA && rd_nack_q) begin
                  state_q <= ST_IGNORE;
               end
            end else if (bit_cnt_q == 4'(BYTE_BITS)) begin
               if (state_q == ST_ADDR && shift_q[7:1] != OWN_ADDR) begin
                  state_q <= ST_IGNORE;
               end else begin
                  ack_slot_q <= 1'b1;
               end
            end
         end
      end
   end

   // Pointer and register storage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q    <= 8'h00;
         pos_code <= POS_RESET;
         neg_code <= NEG_RESET;
         dis_en   <= DIS_RESET;
      end else if (!start_det && !stop_det && scl_fall && !ack_slot_q
                   && bit_cnt_q == 4'(BYTE_BITS)) begin
         if (state_q == ST_PTR) begin
            ptr_q <= shift_q;
         end else if (state_q == ST_WDATA) begin
            case (ptr_q)
               REG_POS: pos_code <= shift_q[POS_W-1:0];
               REG_NEG: neg_code <= shift_q[NEG_W-1:0];
               REG_DIS: dis_en   <= shift_q[DIS_W-1:0];
               default: ;
            endcase
            ptr_q <= ptr_q + 8'h01;
         end
      end else if (!start_det && !stop_det && scl_fall && ack_slot_q
                   && state_q == ST_RDATA) begin
         ptr_q <= ptr_q + 8'h01;
      end
   end

   // Transmit shifter and pin drive change on clock falls; start, stop, idle and ignore release the line at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_q        <= 8'h00;
         drive_ack_q <= 1'b0;
         sda_o       <= 1'b0;
         sda_oe      <= 1'b0;
      end else if (start_det || stop_det || state_q == ST_IDLE || state_q == ST_IGNORE) begin
         drive_ack_q <= 1'b0;
         sda_oe      <= 1'b0;
         sda_o       <= 1'b0;
      end else if (scl_fall) begin
         if (!ack_slot_q && bit_cnt_q == 4'(BYTE_BITS)) begin
            // Address mismatch is caught by the state update; hold off here
            if (state_q == ST_ADDR && shift_q[7:1] != OWN_ADDR) begin
               sda_oe <= 1'b0;
            end else if (state_q == ST_RDATA) begin
               sda_oe <= 1'b0; // Master owns the acknowledge slot
            end else begin
               drive_ack_q <= 1'b1;
               sda_oe      <= 1'b1;
               sda_o       <= 1'b0;
            end
         end else if (ack_slot_q) begin
            drive_ack_q <= 1'b0;
            if ((state_q == ST_ADDR && shift_q[0])
                || (state_q == ST_RDATA && !rd_nack_q)) begin
               tx_q   <= {rd_next[6:0], 1'b0};
               sda_oe <= ~rd_next[7];
               sda_o  <= 1'b0;
            end else begin
               sda_oe <= 1'b0;
            end
         end else if (state_q == ST_RDATA) begin
            // Open drain: a one is sent by releasing the line
            sda_oe <= ~tx_q[7];
            tx_q   <= {tx_q[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else begin
         busy <= (state_q != ST_IDLE);
      end
   end

   // Checks run on the synchronised pins, so bus edges show up two cycles late
   a_ack_on_match: assert property (@(posedge clk) disable iff (!rst_n)
      drive_ack_q |-> sda_oe && !sda_o)
      else $error("Acknowledge slot not driven low");
   a_ack_in_slot: assert property (@(posedge clk) disable iff (!rst_n)
      (ack_slot_q && scl_rise && state_q != ST_RDATA) |-> sda_oe)
      else $error("Acknowledge missing while clock high");
   a_stop_to_idle: assert property (@(posedge clk) disable iff (!rst_n)
      stop_det |=> state_q == ST_IDLE)
      else $error("Stop did not return to idle");
   a_start_to_addr: assert property (@(posedge clk) disable iff (!rst_n)
      start_det |=> state_q == ST_ADDR && bit_cnt_q == 4'h0)
      else $error("Start did not restart address reception");
   a_sda_stable_high: assert property (@(posedge clk) disable iff (!rst_n)
      (scl_s && scl_d1_q && !start_det && !stop_det) |=> $stable(sda_oe))
      else $error("Data drive changed while clock high");
   a_idle_released: assert property (@(posedge clk) disable iff (!rst_n)
      state_q == ST_IDLE |=> !sda_oe)
      else $error("Line driven while idle");
   a_ignore_released: assert property (@(posedge clk) disable iff (!rst_n)
      state_q == ST_IGNORE |=> !sda_oe)
      else $error("Line driven after address mismatch");
   a_mismatch_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_ADDR && scl_fall && !ack_slot_q && bit_cnt_q == 4'(BYTE_BITS)
       && shift_q[7:1] != OWN_ADDR && !start_det && !stop_det)
      |=> state_q == ST_IGNORE && !sda_oe)
      else $error("Foreign address was answered");
   a_dir_select: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_ADDR && ack_slot_q && scl_fall && !start_det && !stop_det)
      |=> state_q == ($past(shift_q[0]) ? ST_RDATA : ST_PTR))
      else $error("Direction bit not followed");
   a_ptr_load: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_PTR && scl_fall && !ack_slot_q && bit_cnt_q == 4'(BYTE_BITS)
       && !start_det && !stop_det)
      |=> ptr_q == $past(shift_q))
      else $error("Pointer byte not loaded");
   a_write_advance: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_WDATA && scl_fall && !ack_slot_q && bit_cnt_q == 4'(BYTE_BITS)
       && !start_det && !stop_det) |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("Pointer did not advance after write");
   a_pos_store: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_WDATA && ptr_q == REG_POS && scl_fall && !ack_slot_q
       && bit_cnt_q == 4'(BYTE_BITS) && !start_det && !stop_det)
      |=> pos_code == $past(shift_q[3:0]))
      else $error("Positive code not stored");
   a_neg_store: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_WDATA && ptr_q == REG_NEG && scl_fall && !ack_slot_q
       && bit_cnt_q == 4'(BYTE_BITS) && !start_det && !stop_det)
      |=> neg_code == $past(shift_q[3:0]))
      else $error("Negative code not stored");
   a_dis_store: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_WDATA && ptr_q == REG_DIS && scl_fall && !ack_slot_q
       && bit_cnt_q == 4'(BYTE_BITS) && !start_det && !stop_det)
      |=> dis_en == $past(shift_q[1:0]))
      else $error("Discharge enables not stored");
   a_read_msb: assert property (@(posedge clk) disable iff (!rst_n)
      (ack_slot_q && scl_fall && !start_det && !stop_det
       && ((state_q == ST_ADDR && shift_q[0]) || (state_q == ST_RDATA && !rd_nack_q)))
      |=> sda_oe)
      else $error("Read byte did not open with a low top bit");
   a_read_advance: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_RDATA && ack_slot_q && scl_fall && !start_det && !stop_det)
      |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("Pointer did not advance after read");
   a_read_release: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == ST_RDATA && ack_slot_q && rd_nack_q && scl_fall && !start_det && !stop_det)
      |=> state_q == ST_IGNORE && !sda_oe)
      else $error("Read not ended after master refusal");
   a_nack_hold: assert property (@(posedge clk) disable iff (!rst_n)
      rd_nack_q |-> !sda_oe)
      else $error("Line driven after master refusal");
   a_busy_level: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> busy == $past(state_q != ST_IDLE))
      else $error("Busy does not follow the transfer state");
   a_bit_count: assert property (@(posedge clk) disable iff (!rst_n)
      bit_cnt_q <= 4'(BYTE_BITS))
      else $error("Bit count overran a byte");

   // Main scenarios
   c_write: cover property (@(posedge clk) disable iff (!rst_n)
      state_q == ST_WDATA ##[1:1000] stop_det);
   c_read: cover property (@(posedge clk) disable iff (!rst_n)
      state_q == ST_RDATA ##[1:1000] stop_det);
   c_mismatch: cover property (@(posedge clk) disable iff (!rst_n) state_q == ST_IGNORE);
   c_read_more: cover property (@(posedge clk) disable iff (!rst_n)
      state_q == ST_RDATA && ack_slot_q && !rd_nack_q && scl_fall);
   c_restart: cover property (@(posedge clk) disable iff (!rst_n)
      start_det && state_q == ST_WDATA);
endmodule
`default_nettype wire

// File: lcd_bias_pkg.sv
// Constants shared by the LCD bias I2C target port
package lcd_bias_pkg;
   localparam logic [6:0] TARGET_ADDR   = 7'h3e;
   localparam logic [7:0] REG_POS       = 8'h00;
   localparam logic [7:0] REG_NEG       = 8'h01;
   localparam logic [7:0] REG_DIS       = 8'h03;
   localparam int         POS_W         = 4;
   localparam int         NEG_W         = 4;
   localparam int         DIS_W         = 2;
   localparam logic [3:0] POS_RESET     = 4'h0;
   localparam logic [3:0] NEG_RESET     = 4'h0;
   localparam logic [1:0] DIS_RESET     = 2'h0;
   localparam int         SYNC_STAGES   = 2;
   localparam int         BYTE_BITS     = 8;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_PTR,
      ST_WDATA,
      ST_RDATA,
      ST_IGNORE
   } port_state_e;
endpackage

// File: lcd_bias_sync.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module lcd_bias_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Level in and out
   input  wire logic d,
   output var  logic q
);
   logic meta_q;

   // First stage is read only by the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RESET_VAL;
         q      <= RESET_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// File: lcd_bias_master_model.sv
// Bus master model: makes the serial clock and pulls the data line low
`timescale 1ns/1ps
`default_nettype none
module lcd_bias_master_model (
   // Clock
   input  wire logic clk,
   // Bus lines
   input  wire logic sda_in,
   output var  logic scl_out,
   output var  logic sda_low
);
   initial begin
      scl_out = 1'b1;
      sda_low = 1'b0;
   end
   // Half of the 200 ns bus period
   task automatic half();
      repeat (4) @(negedge clk);
   endtask
   // Data moves mid-way through the low phase and is read at the end of the high phase
   task automatic bit_xfer(input logic b, output logic r);
      repeat (2) @(negedge clk);
      sda_low = ~b;
      repeat (2) @(negedge clk);
      scl_out = 1'b1;
      half();
      r = sda_in;
      scl_out = 1'b0;
   endtask
   // Also a repeated start; the long low phase lets the target drop its acknowledge first
   task automatic start();
      sda_low = 1'b0;
      repeat (2) half();
      scl_out = 1'b1;
      half();
      sda_low = 1'b1;
      half();
      scl_out = 1'b0;
   endtask
   task automatic stop();
      repeat (2) @(negedge clk);
      sda_low = 1'b1;
      half();
      scl_out = 1'b1;
      half();
      sda_low = 1'b0;
      half();
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
      bit_xfer(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bit_xfer(1'b1, r);
         d = {d[6:0], r};
      end
      bit_xfer(~ack, r);
   endtask
endmodule
`default_nettype wire

// File: lcd_bias_i2c_slave_port_tb_top.sv
// Self-checking bench for the LCD bias I2C target port
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
   end \
end
module lcd_bias_i2c_slave_port_tb_top;
   import lcd_bias_pkg::*;
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   wire  logic       scl;
   wire  logic       sda;
   wire  logic       m_low;
   logic             sda_o;
   logic             sda_oe;
   logic [POS_W-1:0] pos_code;
   logic [NEG_W-1:0] neg_code;
   logic [DIS_W-1:0] dis_en;
   logic             busy;
   logic             prev_oe = 1'b0;
   logic             prev_scl = 1'b1;
   logic             ack;
   logic             rb;
   logic [7:0]       rd;
   int               bad_count = 0;
   int               checked = 0;
   int               cycles = 0;
   int               mdl [256];
   // Pull-up wins unless someone pulls low
   assign sda = ~(m_low | (sda_oe & ~sda_o));
   initial forever #12.5 clk = ~clk;
   lcd_bias_master_model m (.clk(clk), .sda_in(sda), .scl_out(scl), .sda_low(m_low));
   lcd_bias_i2c_slave_port dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .pos_code(pos_code), .neg_code(neg_code),
      .dis_en(dis_en), .busy(busy));
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      if (rst_n && scl && prev_scl)
         `CHK("sda_oe held while clock high", prev_oe, sda_oe)
      prev_oe <= sda_oe;
      prev_scl <= scl;
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic check_outputs();
      repeat (8) @(negedge clk);
      `CHK("pos_code", mdl[0], pos_code)
      `CHK("neg_code", mdl[1], neg_code)
      `CHK("dis_en", mdl[3], dis_en)
      `CHK("busy", 1'b0, busy)
      `CHK("sda_oe idle", 1'b0, sda_oe)
   endtask
   task automatic addr_ptr(input int p);
      m.start();
      m.wbyte({TARGET_ADDR, 1'b0}, ack);
      `CHK("addr ack", 1'b1, ack)
      m.wbyte(p[7:0], ack);
      `CHK("ptr ack", 1'b1, ack)
      `CHK("busy in transfer", 1'b1, busy)
   endtask
   task automatic write_seq(input int p, input int n);
      int d;
      addr_ptr(p);
      for (int i = 0; i < n; i++) begin
         d = $urandom_range(255, 0);
         m.wbyte(d[7:0], ack);
         `CHK("data ack", 1'b1, ack)
         if (p == 0 || p == 1) mdl[p] = d & 15;
         if (p == 3) mdl[p] = d & 3;
         p = (p + 1) & 255;
      end
      m.stop();
      check_outputs();
   endtask
   task automatic read_seq(input int p, input int n);
      addr_ptr(p);
      m.start();
      m.wbyte({TARGET_ADDR, 1'b1}, ack);
      `CHK("read addr ack", 1'b1, ack)
      for (int i = 0; i < n; i++) begin
         m.rbyte(i < n - 1, rd);
         `CHK("read data", mdl[p], rd)
         p = (p + 1) & 255;
      end
      m.stop();
      check_outputs();
   endtask
   initial begin
      logic [6:0] a;
      void'($urandom(32'hf0cebd03));
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      check_outputs();
      $display("test reset done");
      write_seq(0, 4);
      read_seq(0, 4);
      write_seq(255, 2);
      read_seq(1, 3);
      $display("test write and read done");
      for (int i = 0; i < 4; i++) begin
         a = 7'($urandom_range(127, 0));
         if (a == TARGET_ADDR) a = a ^ 7'h01;
         m.start();
         m.wbyte({a, i[0]}, ack);
         `CHK("foreign addr ack", 1'b0, ack)
         m.wbyte(8'h00, ack);
         `CHK("ignored byte ack", 1'b0, ack)
         m.stop();
         check_outputs();
      end
      $display("test foreign address done");
      addr_ptr(0);
      for (int i = 0; i < 4; i++) m.bit_xfer(1'b1, rb);
      m.stop();
      check_outputs();
      m.start();
      m.wbyte({TARGET_ADDR, 1'b0}, ack);
      for (int i = 0; i < 3; i++) m.bit_xfer(1'b0, rb);
      write_seq(1, 1);
      read_seq(0, 2);
      $display("test abort done");
      // Reset in the middle of a transfer clears every register
      addr_ptr(3);
      rst_n = 1'b0;
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      foreach (mdl[i]) mdl[i] = 0;
      m.stop();
      check_outputs();
      write_seq(3, 1);
      read_seq(3, 1);
      $display("test reset mid-run done");
      test_done();
   end
endmodule
`default_nettype wire
